// file: rtl/rch_defines.vh
// register map, field positions and timing constants for the camera hub config block
`ifndef RCH_DEFINES_VH
`define RCH_DEFINES_VH

`define RCH_ADDR_W        8
`define RCH_REG_PORT_CFG  8'h6d
`define RCH_REG_PORT_SEL  8'h60
`define RCH_REG_VC_DT     8'h61
`define RCH_REG_FWD       8'h62
`define RCH_REG_LANE      8'h63
`define RCH_REG_STATUS    8'h64

`define RCH_CFG_CABLE_BIT 2
`define RCH_MODE_RSVD     2'h0
`define RCH_MODE_12LF     2'h1
`define RCH_MODE_12HF     2'h2
`define RCH_MODE_10       2'h3

`define RCH_FWD_DUP_BIT   4
`define RCH_LANE_ULPS_BIT 0
`define RCH_LANE_NUM_LSB  4
`define RCH_LANE_DEFAULT  4'h4
`define RCH_SYNC_FULL     2'h3
`define RCH_HF_LAST       2'h2

`define RCH_VC_LSB        6
`define RCH_DT_RAW10      6'h2b
`define RCH_DT_RAW12      6'h2c

`define RCH_CLK_MHZ       10
`define RCH_LPX_NS        50
`define RCH_WAKEUP_MS     1

`endif

// file: rtl/rch_hub_config.v
// per-port raw mode, stream tagging and forwarding for the four-input camera hub
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ns
`include "rch_defines.vh"
module rch_hub_config #(
  parameter NPORT      = 4,
  parameter WAKEUP_CYC = (`RCH_WAKEUP_MS * 1000000 * `RCH_CLK_MHZ + 999) / 1000
) (
  // clock and reset
  input  wire                   clk_i,
  input  wire                   rstn_i,
  // mode strap
  input  wire [2:0]             strap_mode_i,
  // register port
  input  wire [`RCH_ADDR_W-1:0] addr_i,
  input  wire [7:0]             wdata_i,
  input  wire                   wr_i,
  input  wire                   rd_i,
  output reg  [7:0]             rdata_o,
  // pixel stream in, one word per port
  input  wire [NPORT-1:0]       px_valid_i,
  input  wire [NPORT*12-1:0]    px_data_i,
  input  wire [NPORT-1:0]       px_short_i,
  // packet word to the two transmitters
  output reg  [1:0]             tx_valid_o,
  output reg  [1:0]             tx_short_o,
  output reg  [1:0]             tx_vc0_o,
  output reg  [1:0]             tx_vc1_o,
  output reg  [5:0]             tx_dt0_o,
  output reg  [5:0]             tx_dt1_o,
  output reg  [11:0]            tx_data0_o,
  output reg  [11:0]            tx_data1_o,
  // lane state and word clock enable
  output reg  [1:0]             lane_lp_o,
  output reg  [1:0]             lane_ready_o,
  output reg  [NPORT-1:0]       word_en_o,
  output reg  [NPORT-1:0]       rx_en_o
);

  localparam LPX_CYC = (`RCH_LPX_NS * `RCH_CLK_MHZ + 999) / 1000;
  localparam [31:0] LPX_N = (LPX_CYC < 1) ? 1 : LPX_CYC;
  localparam [31:0] WAK_N = WAKEUP_CYC;

  localparam ST_LP   = 3'b001;
  localparam ST_HS   = 3'b010;
  localparam ST_ULPS = 3'b100;

  // strap passes three flops; the value is taken once, when the chain is full and the last two agree
  reg  [2:0]         strap_s1;
  reg  [2:0]         strap_s2;
  reg  [2:0]         strap_s3;
  reg  [1:0]         strap_fill;
  reg                strap_done;
  wire               strap_take;

  // register write decode
  wire               wr_sel;
  wire               wr_cfg;
  wire               wr_vcdt;
  wire               wr_fwd;
  wire               wr_lane;

  // settings shared by all ports
  reg  [1:0]         port_sel;
  reg                dup_en;
  reg  [3:0]         lane_cfg;
  reg                ulps_req;
  reg  [1:0]         wcnt;
  reg                wtog;

  // per-port settings, flattened so one reader can index them
  wire [3*NPORT-1:0] cfg_all;
  wire [8*NPORT-1:0] vcdt_all;
  wire [NPORT-1:0]   fwd_all;
  wire [NPORT-1:0]   port_ok;
  wire [NPORT-1:0]   next_word_en;
  wire [2:0]         sel_cfg;
  wire [7:0]         sel_vcdt;
  reg  [7:0]         next_rdata;

  // round-robin merge and lane timing
  reg  [1:0]         rr;
  wire [1:0]         pick;
  wire               pick_ok;
  wire               pick_fwd;
  wire [7:0]         pick_vcdt;
  wire [11:0]        pick_data;
  wire [1:0]         next_lane_lp;
  wire [1:0]         next_lane_ready;

  assign strap_take = !strap_done && (strap_fill == `RCH_SYNC_FULL) && (strap_s2 == strap_s3);

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      strap_s1   <= 3'h0;
      strap_s2   <= 3'h0;
      strap_s3   <= 3'h0;
      strap_fill <= 2'h0;
      strap_done <= 1'b0;
    end else begin
      strap_s1 <= strap_mode_i;
      strap_s2 <= strap_s1;
      strap_s3 <= strap_s2;
      // reset zeros in the chain would otherwise latch a reserved mode
      if (strap_fill != `RCH_SYNC_FULL)
        strap_fill <= strap_fill + 2'h1;
      if (strap_take)
        strap_done <= 1'b1;
    end
  end

  assign wr_sel  = wr_i && (addr_i == `RCH_REG_PORT_SEL);
  assign wr_cfg  = wr_i && (addr_i == `RCH_REG_PORT_CFG);
  assign wr_vcdt = wr_i && (addr_i == `RCH_REG_VC_DT);
  assign wr_fwd  = wr_i && (addr_i == `RCH_REG_FWD);
  assign wr_lane = wr_i && (addr_i == `RCH_REG_LANE);

  // 12HF keeps two slots of three, 10-bit one of two
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wcnt <= 2'h0;
      wtog <= 1'b0;
    end else begin
      wcnt <= (wcnt == `RCH_HF_LAST) ? 2'h0 : wcnt + 2'h1;
      wtog <= !wtog;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NPORT; g = g + 1) begin : g_port
      localparam [1:0] VC_DEF = g;
      reg  [2:0] cfg;
      reg  [7:0] vcdt;
      reg        fwd;
      reg        en_c;
      wire       sel_me;
      wire [5:0] dt_def;

      assign sel_me = (port_sel == g);
      assign dt_def = (strap_s3[1:0] == `RCH_MODE_10) ? `RCH_DT_RAW10 : `RCH_DT_RAW12;

      // strap is taken once after release; software owns the fields after that
      always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          cfg  <= 3'h0;
          vcdt <= 8'h00;
          fwd  <= 1'b0;
        end else begin
          if (strap_take)
            cfg <= strap_s3;
          else if (wr_cfg && sel_me)
            cfg <= wdata_i[2:0];
          if (strap_take)
            vcdt <= {VC_DEF, dt_def};
          else if (wr_vcdt && sel_me)
            vcdt <= wdata_i;
          if (wr_fwd)
            fwd <= wdata_i[g];
        end
      end

      always @* begin
        case (cfg[1:0])
          `RCH_MODE_12LF: en_c = 1'b1;
          `RCH_MODE_12HF: en_c = (wcnt != `RCH_HF_LAST);
          `RCH_MODE_10:   en_c = wtog;
          default:        en_c = 1'b0;
        endcase
      end

      assign next_word_en[g]    = en_c;
      assign port_ok[g]         = (cfg[1:0] != `RCH_MODE_RSVD);
      assign cfg_all[3*g +: 3]  = cfg;
      assign vcdt_all[8*g +: 8] = vcdt;
      assign fwd_all[g]         = fwd;
    end
  endgenerate

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      word_en_o <= {NPORT{1'b0}};
      rx_en_o   <= {NPORT{1'b0}};
    end else begin
      word_en_o <= next_word_en;
      rx_en_o   <= port_ok;
    end
  end

  // register block: 0x6D and 0x61 act on the port picked by the select register
  assign sel_cfg  = cfg_all[3*port_sel +: 3];
  assign sel_vcdt = vcdt_all[8*port_sel +: 8];

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      port_sel <= 2'h0;
      dup_en   <= 1'b0;
      lane_cfg <= `RCH_LANE_DEFAULT;
      ulps_req <= 1'b0;
    end else begin
      if (wr_sel)
        port_sel <= wdata_i[1:0];
      if (wr_fwd)
        dup_en <= wdata_i[`RCH_FWD_DUP_BIT];
      if (wr_lane) begin
        ulps_req <= wdata_i[`RCH_LANE_ULPS_BIT];
        lane_cfg <= wdata_i[7:`RCH_LANE_NUM_LSB];
      end
    end
  end

  // read data stands for one cycle only, zero otherwise
  always @* begin
    next_rdata = 8'h00;
    if (rd_i) begin
      case (addr_i)
        `RCH_REG_PORT_CFG: next_rdata = {5'h00, sel_cfg};
        `RCH_REG_PORT_SEL: next_rdata = {6'h00, port_sel};
        `RCH_REG_VC_DT:    next_rdata = sel_vcdt;
        `RCH_REG_FWD:      next_rdata = {3'h0, dup_en, fwd_all[3:0]};
        `RCH_REG_LANE:     next_rdata = {lane_cfg, 3'h0, ulps_req};
        `RCH_REG_STATUS:   next_rdata = {2'h0, lane_ready_o, port_ok[3:0]};
        default:           next_rdata = 8'h00;
      endcase
    end
  end

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i)
      rdata_o <= 8'h00;
    else
      rdata_o <= next_rdata;
  end

  // round-robin merge: each receive port gets one slot in four
  assign pick      = rr;
  assign pick_ok   = px_valid_i[pick] && port_ok[pick] && word_en_o[pick];
  assign pick_fwd  = fwd_all[pick];
  assign pick_vcdt = vcdt_all[8*pick +: 8];
  assign pick_data = px_data_i[12*pick +: 12];

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rr         <= 2'h0;
      tx_valid_o <= 2'h0;
      tx_short_o <= 2'h0;
      tx_vc0_o   <= 2'h0;
      tx_vc1_o   <= 2'h0;
      tx_dt0_o   <= 6'h00;
      tx_dt1_o   <= 6'h00;
      tx_data0_o <= 12'h000;
      tx_data1_o <= 12'h000;
    end else begin
      rr <= rr + 2'h1;
      // port 1 takes ports routed to it and, with duplication on, every word port 0 takes as well
      tx_valid_o[0] <= pick_ok && !pick_fwd && lane_ready_o[0];
      tx_valid_o[1] <= pick_ok && (dup_en || pick_fwd) && lane_ready_o[1];
      tx_short_o    <= {2{px_short_i[pick]}};
      tx_vc0_o      <= pick_vcdt[7:`RCH_VC_LSB];
      tx_vc1_o      <= pick_vcdt[7:`RCH_VC_LSB];
      tx_dt0_o      <= pick_vcdt[5:0];
      tx_dt1_o      <= pick_vcdt[5:0];
      tx_data0_o    <= pick_data;
      tx_data1_o    <= pick_data;
    end
  end

  // lane low-power timing, counted in reference clock cycles
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_lane
      reg  [2:0]  st;
      reg  [2:0]  next_st;
      reg  [31:0] cnt;
      reg  [31:0] next_cnt;
      reg         lp_c;
      reg         ready_c;

      always @* begin
        next_st  = st;
        next_cnt = cnt;
        lp_c     = lane_lp_o[g];
        ready_c  = lane_ready_o[g];
        case (st)
          ST_LP: begin
            lp_c     = 1'b1;
            next_cnt = cnt + 32'h0000_0001;
            if (ulps_req) begin
              next_st  = ST_ULPS;
              next_cnt = 32'h0000_0000;
              ready_c  = 1'b0;
            end else if (cnt + 32'h0000_0001 >= LPX_N) begin
              // low-power state has lasted its minimum time
              next_st = ST_HS;
              ready_c = 1'b1;
            end
          end
          ST_HS: begin
            lp_c     = 1'b0;
            next_cnt = 32'h0000_0000;
            if (ulps_req) begin
              next_st = ST_ULPS;
              ready_c = 1'b0;
            end
          end
          ST_ULPS: begin
            // stays out of high speed until the wake-up time has run out
            lp_c = 1'b1;
            if (ulps_req)
              next_cnt = 32'h0000_0000;
            else if (cnt + 32'h0000_0001 >= WAK_N) begin
              next_st  = ST_LP;
              next_cnt = 32'h0000_0000;
            end else
              next_cnt = cnt + 32'h0000_0001;
          end
          default: next_st = ST_LP;
        endcase
      end

      always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          st  <= ST_LP;
          cnt <= 32'h0000_0000;
        end else begin
          st  <= next_st;
          cnt <= next_cnt;
        end
      end

      assign next_lane_lp[g]    = lp_c;
      assign next_lane_ready[g] = ready_c;
    end
  endgenerate

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lane_lp_o    <= 2'h3;
      lane_ready_o <= 2'h0;
    end else begin
      lane_lp_o    <= next_lane_lp;
      lane_ready_o <= next_lane_ready;
    end
  end

endmodule // rch_hub_config

// file: tb/rch_hub_config_monitor.sv
// concurrent checks on the camera hub config block ports
`timescale 1ns/1ns
module rch_hub_config_monitor #(parameter NPORT = 4) (
  // clock and reset
  input wire              clk_i,
  input wire              rstn_i,
  // register port
  input wire [7:0]        addr_i,
  input wire              rd_i,
  input wire [7:0]        rdata_o,
  // streams and lanes
  input wire [NPORT-1:0]  px_valid_i,
  input wire [NPORT*12-1:0] px_data_i,
  input wire [NPORT-1:0]  rx_en_o,
  input wire [1:0]        tx_valid_o,
  input wire [11:0]       tx_data0_o,
  input wire [11:0]       tx_data1_o,
  input wire [1:0]        lane_lp_o,
  input wire [1:0]        lane_ready_o
);
  reg [NPORT*12-1:0] px_d;
  reg [NPORT-1:0]    pv_d;
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      px_d <= 0;
      pv_d <= 0;
    end else begin
      px_d <= px_data_i;
      pv_d <= px_valid_i & rx_en_o;
    end
  end
  // a forwarded word must match some enabled port's word of the previous cycle
  function automatic bit hit(input [11:0] d);
    hit = 0;
    for (int n = 0; n < NPORT; n++) if (pv_d[n] && px_d[12*n+:12] == d) hit = 1;
  endfunction
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  sequence s_rd_gap;
    rd_i && addr_i == 8'h70;
  endsequence
  rd_unmapped_a: assert property (s_rd_gap |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  rd_idle_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("read data outside its cycle");
  fwd_enabled_a: assert property (tx_valid_o != 2'b00 |-> pv_d != 0)
    else $error("word forwarded without enabled source");
  ready_lane0_a: assert property (tx_valid_o[0] |-> $past(lane_ready_o[0]))
    else $error("lane 0 sent while not ready");
  ready_lane1_a: assert property (tx_valid_o[1] |-> $past(lane_ready_o[1]))
    else $error("lane 1 sent while not ready");
  data_src0_a: assert property (tx_valid_o[0] |-> hit(tx_data0_o))
    else $error("port 0 data has no source");
  data_src1_a: assert property (tx_valid_o[1] |-> hit(tx_data1_o))
    else $error("port 1 data has no source");
  hs_not_lp_a: assert property (tx_valid_o[0] |-> !lane_lp_o[0])
    else $error("data sent in low power");
endmodule // rch_hub_config_monitor
bind rch_hub_config rch_hub_config_monitor #(.NPORT(NPORT)) u_mon (.clk_i, .rstn_i, .addr_i,
  .rd_i, .rdata_o, .px_valid_i, .px_data_i, .rx_en_o, .tx_valid_o, .tx_data0_o, .tx_data1_o,
  .lane_lp_o, .lane_ready_o);

// file: tb/rch_csi_rx_model.sv
// receiver model at the far side: counts words seen on both lanes, lane 0 only while in high speed
`timescale 1ns/1ns
module rch_csi_rx_model (
  // clock and reset
  input  wire       clk_i,
  input  wire       rstn_i,
  // lanes
  input  wire [1:0] tx_valid_i,
  input  wire [1:0] lane_lp_i,
  output reg  [7:0] words_o
);
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) words_o <= 8'h00;
    // lane 0 is ignored in low power, as after a burst; lane 1 is counted whenever valid
    else words_o <= words_o + 8'(tx_valid_i[0] & !lane_lp_i[0]) + 8'(tx_valid_i[1]);
  end
endmodule // rch_csi_rx_model

// file: tb/test_rch_hub_config.sv
// self-checking bench for the camera hub config block
`timescale 1ns/1ns
module test_rch_hub_config;
  logic clk_i, rstn_i, wr_i, rd_i;
  logic [2:0] strap_mode_i;
  logic [7:0] addr_i, wdata_i, rdata_o, words;
  logic [3:0] px_valid_i, px_short_i, word_en_o, rx_en_o;
  logic [47:0] px_data_i;
  logic [1:0] tx_valid_o, tx_short_o, tx_vc0_o, tx_vc1_o, lane_lp_o, lane_ready_o;
  logic [5:0] tx_dt0_o, tx_dt1_o;
  logic [11:0] tx_data0_o, tx_data1_o, d;
  logic [20:0] q0[$], q1[$];
  logic [7:0] rq[$], vd[3];
  logic [31:0] rnd = 32'h877d;
  int err_total, num_checks, cyc, n;
  bit rd_seen;
  rch_hub_config #(.WAKEUP_CYC(20)) DUT (.clk_i, .rstn_i, .strap_mode_i, .addr_i, .wdata_i,
    .wr_i, .rd_i, .rdata_o, .px_valid_i, .px_data_i, .px_short_i, .tx_valid_o, .tx_short_o,
    .tx_vc0_o, .tx_vc1_o, .tx_dt0_o, .tx_dt1_o, .tx_data0_o, .tx_data1_o, .lane_lp_o,
    .lane_ready_o, .word_en_o, .rx_en_o);
  rch_csi_rx_model u_rx (.clk_i, .rstn_i, .tx_valid_i(tx_valid_o), .lane_lp_i(lane_lp_o),
    .words_o(words));
  function automatic [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string nm, input logic [20:0] e, input logic [20:0] s);
    num_checks++;
    if (e !== s) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic acc(input [7:0] a, input [7:0] dv, input bit w);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= dv;
    wr_i <= w;
    rd_i <= !w;
    if (!w) rq.push_back(dv);
    @(posedge clk_i);
    wr_i <= 0;
    rd_i <= 0;
  endtask
  task automatic count_en(input int p, output int c);
    c = 0;
    repeat (6) begin
      @(posedge clk_i);
      c += word_en_o[p];
    end
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    clk_i = 0;
    forever #50 clk_i = !clk_i;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      end_sim;
    end
    if (rd_seen) chk("rdata", rq.pop_front(), rdata_o);
    rd_seen = rd_i;
    if (tx_valid_o[0]) chk("tx0", q0.pop_front(), {tx_vc0_o, tx_dt0_o, tx_short_o[0], tx_data0_o});
    if (tx_valid_o[1]) chk("tx1", q1.pop_front(), {tx_vc1_o, tx_dt1_o, tx_short_o[1], tx_data1_o});
  end
  initial begin
    {rstn_i, wr_i, rd_i, addr_i, wdata_i, px_valid_i, px_short_i, px_data_i} = 0;
    strap_mode_i = 3'h6;
    repeat (10) @(posedge clk_i);
    rstn_i <= 1;
    repeat (6) @(posedge clk_i);
    strap_mode_i <= 3'h1; // too late: strap is taken once only
    acc(8'h60, 8'h03, 1);
    acc(8'h6d, 8'h06, 0);
    acc(8'h70, 8'h5a, 1);
    acc(8'h70, 8'h00, 0);
    for (int p = 0; p < 3; p++) begin
      rnd = lfsr(rnd);
      vd[p] = {2'(3 - p), rnd[5:0]};
      acc(8'h60, 8'(p), 1);
      acc(8'h6d, (p == 2) ? 8'h04 : 8'h01, 1);
      acc(8'h61, vd[p], 1);
      acc(8'h6d, (p == 2) ? 8'h04 : 8'h01, 0);
      acc(8'h61, vd[p], 0);
    end
    for (n = 0; n < 200 && lane_ready_o !== 2'b11; n++) @(posedge clk_i);
    for (int r = 0; r < 2; r++) begin
      acc(8'h62, r ? 8'h01 : 8'h02, 1);
      rnd = lfsr(rnd);
      d = rnd[11:0];
      px_data_i <= {12'h0, ~d, d ^ 12'h0f0, d};
      px_short_i <= 4'b0010;
      px_valid_i <= r ? 4'b0001 : 4'b0111;
      if (r) q1.push_back({vd[0], 1'b0, d});
      else begin
        q0.push_back({vd[0], 1'b0, d});
        q1.push_back({vd[1], 1'b1, d ^ 12'h0f0});
      end
      repeat (4) @(posedge clk_i);
      px_valid_i <= 0;
      repeat (4) @(posedge clk_i);
    end
    chk("left", 0, q0.size() + q1.size());
    chk("rx_en2", 0, rx_en_o[2]);
    chk("words", 3, words);
    count_en(3, n);
    chk("word_en3", 4, n);
    acc(8'h60, 8'h01, 1);
    acc(8'h6d, 8'h03, 1);
    repeat (2) @(posedge clk_i);
    count_en(1, n);
    chk("word_en1", 3, n);
    acc(8'h63, 8'h41, 1);
    repeat (5) @(posedge clk_i);
    chk("ulps_lp", 2'h3, lane_lp_o);
    chk("ulps_rdy", 0, lane_ready_o);
    acc(8'h63, 8'h40, 1);
    for (n = 0; n < 500 && lane_ready_o[0] !== 1'b1; n++) @(posedge clk_i);
    chk("wake", 1, n >= 19 && n < 500);
    end_sim;
  end
endmodule // test_rch_hub_config
